// [hw/vcp_top.sv]
/*
  vcp_top: parallel image input port with an AHB-Lite register slave.
  Assumes: the sensor side is source synchronous to pix_clk; configuration is
  written while capture is disabled; pad logic resolves the sync pins from the enables.
*/
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
// Behaviour
// - In raw mode raw bits five to zero come from luma lines five to zero in order.
// - In 16-bit mode the luma lines are luma bits one to one and the chroma lines carry chroma.
// - In 8-bit mode each byte half of the bus carries one multiplexed luma and chroma stream.
// - Line sync marks each new line, is sampled in slave mode and driven in master mode.
// - Frame sync marks each new frame, is sampled in slave mode and driven in master mode.
// - As a write gate the shared pin suppresses pixel writes while it is low.
// - As a field id the shared pin tags incoming data with the arriving field.
// - Progressive and interlaced sources are both handled with no per-field software action.
// - The pixel clock from the source is the sampling strobe for all data lines.
// - In raw mode raw bits thirteen to eight come from chroma lines five to zero.
// - In 16-bit mode a setting picks whether blue or red difference comes first.
// - In 8-bit mode settings pick the component order and which bus half is captured.
module vcp_top (
  input wire logic hclk,                       // bus clock
  input wire logic hresetn,                    // asynchronous reset, active low
  input wire logic hsel,                       // slave select
  input wire logic [31:0] haddr,               // byte address
  input wire logic [1:0] htrans,               // transfer type
  input wire logic hwrite,                     // write when high
  input wire logic [2:0] hsize,                // transfer size, word only
  input wire logic [31:0] hwdata,              // write data
  input wire logic hready,                     // bus ready
  output logic [31:0] hrdata,                  // read data
  output logic hreadyout,                      // slave ready
  output logic hresp,                          // always okay
  input wire logic pix_clk,                    // pixel clock from the source
  input wire logic [7:0] luma_input_lines,     // lower input byte
  input wire logic [7:0] chroma_input_lines,   // upper input byte
  input wire logic line_sync_i,                // line sync pin level
  output logic line_sync_o,                    // line sync drive value
  output logic line_sync_oe,                   // line sync drive enable
  input wire logic frame_sync_i,               // frame sync pin level
  output logic frame_sync_o,                   // frame sync drive value
  output logic frame_sync_oe,                  // frame sync drive enable
  input wire logic write_gate_or_field_id,     // shared gate or field pin
  output vcp_pkg::vcp_pix_type pix_o           // captured pixel, pix_clk domain
);
  import vcp_pkg::*;

  typedef enum {VCP_ST_IDLE, VCP_ST_WAIT, VCP_ST_RUN} vcp_state_type;

  // ------------------------------------------------------------
  // bus side state
  // ------------------------------------------------------------
  logic en_r;
  vcp_cfg_type cfg_r;
  vcp_tim_type tim_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] acc_addr_r;
  logic [31:0] rd_nxt;
  logic [15:0] frame_cnt_r;
  logic [13:0] line_cnt_r;
  logic [3:0] xs_q;
  logic [1:0] xs_prev_r;
  logic frame_evt;
  logic line_evt;
  logic acc;

  // ------------------------------------------------------------
  // pixel side state
  // ------------------------------------------------------------
  logic pix_rst_n;
  logic en_pix;
  vcp_cfg_type pcfg_r;
  vcp_tim_type ptim_r;
  logic [7:0] pos_y_r, pos_c_r, neg_y_r, neg_c_r;
  logic [2:0] pos_ctl_r, neg_ctl_r;
  logic [7:0] smp_y_r, smp_c_r;
  logic smp_hs_r, smp_vs_r, smp_wf_r;
  logic [15:0] hcnt_r, vcnt_r;
  logic hs_prev_r, vs_prev_r;
  logic hs_lvl, vs_lvl, sol, sof;
  logic [1:0] ph_r;
  logic field_r;
  logic frame_tgl_r, line_tgl_r;
  vcp_state_type state_r, state_nxt;
  logic [15:0] word;
  vcp_comp_type comp;

  // ------------------------------------------------------------
  // ahb-lite slave
  // ------------------------------------------------------------
  assign acc = hsel & hready & htrans[VCP_HTRANS_ACTIVE];

  // address phase capture; reads insert one wait state so that a read right
  // after a write always sees the freshly written value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      acc_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= acc & hwrite;
      rd_pend_r <= acc & ~hwrite;
      if (acc) begin
        acc_addr_r <= haddr[7:0];
      end
    end
  end

  // ready, response and read data all come from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      if (acc & ~hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_r) begin
        hreadyout <= 1'b1;
        hrdata <= rd_nxt;
      end
    end
  end

  // read decode; unmapped words read as zero
  always_comb begin
    rd_nxt = 32'h00000000;
    if (acc_addr_r == VCP_OFS_CTRL) begin
      rd_nxt[9:0] = {cfg_r, en_r};
    end else if (acc_addr_r == VCP_OFS_HTIM) begin
      rd_nxt = {tim_r.hwidth, tim_r.hperiod};
    end else if (acc_addr_r == VCP_OFS_VTIM) begin
      rd_nxt = {tim_r.vwidth, tim_r.vperiod};
    end else if (acc_addr_r == VCP_OFS_STAT) begin
      rd_nxt[VCP_STAT_FRAMES +: 16] = frame_cnt_r;
      rd_nxt[VCP_STAT_LINES +: 14] = line_cnt_r;
      rd_nxt[VCP_STAT_FIELD] = xs_q[2];
      rd_nxt[VCP_STAT_RUN] = xs_q[3];
    end
  end

  // control register; mode, direction and layout only change while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cfg_r, en_r} <= VCP_CTRL_RST;
    end else if (wr_pend_r && acc_addr_r == VCP_OFS_CTRL) begin
      en_r <= hwdata[VCP_CTRL_EN];
      if (!en_r) begin
        cfg_r <= hwdata[9:1];
      end
    end
  end

  // sync timing for master mode, also locked while capturing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tim_r <= {VCP_HWIDTH_RST, VCP_HPERIOD_RST, VCP_VWIDTH_RST, VCP_VPERIOD_RST};
    end else if (wr_pend_r && !en_r) begin
      if (acc_addr_r == VCP_OFS_HTIM) begin
        {tim_r.hwidth, tim_r.hperiod} <= hwdata;
      end else if (acc_addr_r == VCP_OFS_VTIM) begin
        {tim_r.vwidth, tim_r.vperiod} <= hwdata;
      end
    end
  end

  // ------------------------------------------------------------
  // crossings between the two clocks
  // ------------------------------------------------------------
  // pixel domain reset: asserted at once, released on pix_clk
  vcp_sync2 u_pix_rst (
    .clk(pix_clk),
    .rst_n(hresetn),
    .d(1'b1),
    .q(pix_rst_n)
  );

  // enable level into the pixel domain
  vcp_sync2 u_en_sync (
    .clk(pix_clk),
    .rst_n(pix_rst_n),
    .d(en_r),
    .q(en_pix)
  );

  // boundary toggles and status levels into the bus domain
  generate
    for (genvar gi = 0; gi < 4; gi++) begin : g_xs
      vcp_sync2 u_xs (
        .clk(hclk),
        .rst_n(hresetn),
        .d(gi == 0 ? frame_tgl_r : gi == 1 ? line_tgl_r : gi == 2 ? field_r : (state_r == VCP_ST_RUN)),
        .q(xs_q[gi])
      );
    end
  endgenerate

  assign frame_evt = xs_q[0] ^ xs_prev_r[0];
  assign line_evt = xs_q[1] ^ xs_prev_r[1];

  // frame and line counters seen by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xs_prev_r <= 2'h0;
      frame_cnt_r <= 16'h0000;
      line_cnt_r <= 14'h0000;
    end else begin
      xs_prev_r <= xs_q[1:0];
      if (frame_evt) begin
        frame_cnt_r <= frame_cnt_r + 16'h0001;
      end
      if (frame_evt) begin
        line_cnt_r <= {13'h0000, line_evt};
      end else if (line_evt) begin
        line_cnt_r <= line_cnt_r + 14'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // pixel side configuration snapshot
  // ------------------------------------------------------------
  // software changes the settings only while disabled, and the enable
  // arrives two pixel clocks late, so the snapshot is stable when used
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      pcfg_r <= VCP_CTRL_RST[9:1];
      ptim_r <= {VCP_HWIDTH_RST, VCP_HPERIOD_RST, VCP_VWIDTH_RST, VCP_VPERIOD_RST};
    end else if (!en_pix) begin
      pcfg_r <= cfg_r;
      ptim_r <= tim_r;
    end
  end

  // ------------------------------------------------------------
  // pin sampling on both pixel clock edges
  // ------------------------------------------------------------
  // the source is synchronous to pix_clk, so no synchroniser is needed here
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      pos_y_r <= 8'h00;
      pos_c_r <= 8'h00;
      pos_ctl_r <= 3'h0;
    end else begin
      pos_y_r <= luma_input_lines;
      pos_c_r <= chroma_input_lines;
      pos_ctl_r <= {write_gate_or_field_id, frame_sync_i, line_sync_i};
    end
  end

  always_ff @(negedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      neg_y_r <= 8'h00;
      neg_c_r <= 8'h00;
      neg_ctl_r <= 3'h0;
    end else begin
      neg_y_r <= luma_input_lines;
      neg_c_r <= chroma_input_lines;
      neg_ctl_r <= {write_gate_or_field_id, frame_sync_i, line_sync_i};
    end
  end

  // edge select; falling edge data costs no extra latency on the rising stage
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      smp_y_r <= 8'h00;
      smp_c_r <= 8'h00;
      {smp_wf_r, smp_vs_r, smp_hs_r} <= 3'h0;
    end else if (pcfg_r.neg_edge) begin
      smp_y_r <= neg_y_r;
      smp_c_r <= neg_c_r;
      {smp_wf_r, smp_vs_r, smp_hs_r} <= neg_ctl_r;
    end else begin
      smp_y_r <= pos_y_r;
      smp_c_r <= pos_c_r;
      {smp_wf_r, smp_vs_r, smp_hs_r} <= pos_ctl_r;
    end
  end

  // ------------------------------------------------------------
  // master mode sync generator
  // ------------------------------------------------------------
  // a period of zero is treated as one to keep the counters bounded
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      hcnt_r <= 16'h0000;
      vcnt_r <= 16'h0000;
    end else if (!(en_pix && pcfg_r.master)) begin
      hcnt_r <= 16'h0000;
      vcnt_r <= 16'h0000;
    end else if (hcnt_r + 16'h0001 >= ptim_r.hperiod) begin
      hcnt_r <= 16'h0000;
      vcnt_r <= (vcnt_r + 16'h0001 >= ptim_r.vperiod) ? 16'h0000 : vcnt_r + 16'h0001;
    end else begin
      hcnt_r <= hcnt_r + 16'h0001;
    end
  end

  // sync drive: active high pulses, released while slave or disabled
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      line_sync_o <= 1'b0;
      line_sync_oe <= 1'b0;
      frame_sync_o <= 1'b0;
      frame_sync_oe <= 1'b0;
    end else begin
      line_sync_oe <= en_pix & pcfg_r.master;
      frame_sync_oe <= en_pix & pcfg_r.master;
      line_sync_o <= en_pix & pcfg_r.master & (hcnt_r < ptim_r.hwidth);
      frame_sync_o <= en_pix & pcfg_r.master & (vcnt_r < ptim_r.vwidth);
    end
  end

  // ------------------------------------------------------------
  // line and frame boundaries
  // ------------------------------------------------------------
  assign hs_lvl = pcfg_r.master ? line_sync_o : smp_hs_r;
  assign vs_lvl = pcfg_r.master ? frame_sync_o : smp_vs_r;
  assign sol = hs_lvl & ~hs_prev_r;
  assign sof = vs_lvl & ~vs_prev_r;

  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      hs_prev_r <= 1'b0;
      vs_prev_r <= 1'b0;
    end else begin
      hs_prev_r <= hs_lvl;
      vs_prev_r <= vs_lvl;
    end
  end

  // capture sequencing: start on a clean frame, stop at once on disable
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      VCP_ST_IDLE: begin
        if (en_pix) begin
          state_nxt = VCP_ST_WAIT;
        end
      end
      VCP_ST_WAIT: begin
        if (!en_pix) begin
          state_nxt = VCP_ST_IDLE;
        end else if (sof) begin
          state_nxt = VCP_ST_RUN;
        end
      end
      VCP_ST_RUN: begin
        if (!en_pix) begin
          state_nxt = VCP_ST_IDLE;
        end
      end
      default: state_nxt = VCP_ST_IDLE;
    endcase
  end

  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      state_r <= VCP_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // sample phase within the line and boundary toggles for the bus side
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      ph_r <= 2'h0;
      frame_tgl_r <= 1'b0;
      line_tgl_r <= 1'b0;
    end else begin
      ph_r <= sol ? 2'h1 : ph_r + 2'h1;
      if (en_pix && sof) begin
        frame_tgl_r <= ~frame_tgl_r;
      end
      if (en_pix && sol) begin
        line_tgl_r <= ~line_tgl_r;
      end
    end
  end

  // field tag is latched per frame, so interlaced sources need no software
  // help; with the pin used as a gate every frame is field zero
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      field_r <= 1'b0;
    end else if (!pcfg_r.field_pin) begin
      field_r <= 1'b0;
    end else if (sof) begin
      field_r <= smp_wf_r;
    end
  end

  // ------------------------------------------------------------
  // word assembly per input mode
  // ------------------------------------------------------------
  function automatic vcp_comp_type comp8(input logic [1:0] ord, input logic [1:0] ph);
    vcp_comp_type c;
    c = VCP_COMP_Y;
    case (ord)
      2'h0: c = ph[0] ? VCP_COMP_Y : (ph[1] ? VCP_COMP_CR : VCP_COMP_CB);
      2'h1: c = ph[0] ? VCP_COMP_Y : (ph[1] ? VCP_COMP_CB : VCP_COMP_CR);
      2'h2: c = !ph[0] ? VCP_COMP_Y : (ph[1] ? VCP_COMP_CR : VCP_COMP_CB);
      default: c = !ph[0] ? VCP_COMP_Y : (ph[1] ? VCP_COMP_CB : VCP_COMP_CR);
    endcase
    return c;
  endfunction

  // the phase of the current sample is zero on the line start itself
  always_comb begin
    word = 16'h0000;
    comp = VCP_COMP_Y;
    case (pcfg_r.mode)
      VCP_MODE_RAW: begin
        word[5:0] = smp_y_r[5:0];
        word[7:6] = smp_y_r[7:6];
        word[13:8] = smp_c_r[5:0];
      end
      VCP_MODE_YC16: begin
        word = {smp_c_r, smp_y_r};
        comp = ((sol ? 1'b0 : ph_r[0]) == pcfg_r.cr_first) ? VCP_COMP_CB : VCP_COMP_CR;
      end
      VCP_MODE_YC8: begin
        word[7:0] = pcfg_r.half_up ? smp_c_r : smp_y_r;
        comp = comp8(pcfg_r.ord8, sol ? 2'h0 : ph_r);
      end
      default: begin
        word = 16'h0000;
      end
    endcase
  end

  // pixel output; the write gate only qualifies writes when the shared pin
  // is configured as a gate
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      pix_o <= '0;
    end else begin
      pix_o.valid <= (state_r == VCP_ST_RUN || (state_r == VCP_ST_WAIT && en_pix && sof)) && en_pix
                     && (pcfg_r.field_pin || smp_wf_r);
      pix_o.sof <= sof;
      pix_o.sol <= sol;
      pix_o.field <= (pcfg_r.field_pin && sof) ? smp_wf_r : field_r;
      pix_o.comp <= comp;
      pix_o.data <= word;
    end
  end

endmodule

// [hw/vcp_pkg.sv]
/*
  vcp_pkg: shared constants and carrier types of the video capture input port.
  Assumes: a 32-bit AHB-Lite register bus on hclk and a pixel clock from the sensor side.
*/
package vcp_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, low address byte only)
  // ------------------------------------------------------------
  localparam logic [7:0] VCP_OFS_CTRL = 8'h00;
  localparam logic [7:0] VCP_OFS_HTIM = 8'h04;
  localparam logic [7:0] VCP_OFS_VTIM = 8'h08;
  localparam logic [7:0] VCP_OFS_STAT = 8'h0C;

  // ------------------------------------------------------------
  // control register field positions
  // ------------------------------------------------------------
  localparam int VCP_CTRL_EN = 0;
  localparam int VCP_CTRL_MODE = 1;      // two bits
  localparam int VCP_CTRL_MASTER = 3;
  localparam int VCP_CTRL_FIELD_PIN = 4;
  localparam int VCP_CTRL_CR_FIRST = 5;
  localparam int VCP_CTRL_ORD8 = 6;      // two bits
  localparam int VCP_CTRL_HALF_UP = 8;
  localparam int VCP_CTRL_NEG_EDGE = 9;

  // status register field positions
  localparam int VCP_STAT_FRAMES = 0;    // sixteen bits
  localparam int VCP_STAT_LINES = 16;    // fourteen bits
  localparam int VCP_STAT_FIELD = 30;
  localparam int VCP_STAT_RUN = 31;

  // ------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------
  localparam logic [9:0] VCP_CTRL_RST = 10'h000;
  localparam logic [15:0] VCP_HPERIOD_RST = 16'h0360;
  localparam logic [15:0] VCP_HWIDTH_RST = 16'h0010;
  localparam logic [15:0] VCP_VPERIOD_RST = 16'h020D;
  localparam logic [15:0] VCP_VWIDTH_RST = 16'h0003;

  // ahb transfer type bit that marks an active transfer
  localparam int VCP_HTRANS_ACTIVE = 1;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {VCP_MODE_RAW, VCP_MODE_YC16, VCP_MODE_YC8} vcp_mode_type;
  typedef enum logic [1:0] {VCP_COMP_Y, VCP_COMP_CB, VCP_COMP_CR} vcp_comp_type;

  typedef struct packed {
    logic neg_edge;
    logic half_up;
    logic [1:0] ord8;
    logic cr_first;
    logic field_pin;
    logic master;
    vcp_mode_type mode;
  } vcp_cfg_type;

  typedef struct packed {
    logic [15:0] hwidth;
    logic [15:0] hperiod;
    logic [15:0] vwidth;
    logic [15:0] vperiod;
  } vcp_tim_type;

  typedef struct packed {
    logic valid;
    logic sof;
    logic sol;
    logic field;
    vcp_comp_type comp;
    logic [15:0] data;
  } vcp_pix_type;

endpackage

// [hw/vcp_sync2.sv]
/*
  vcp_sync2: two flip-flop level synchroniser.
  Assumes: d is a level that stays put for at least two destination clock edges.
*/
`timescale 1ns/100ps
module vcp_sync2 (
  input wire logic clk,   // destination clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic d,     // level from another domain
  output logic q          // level in the clk domain
);

  logic meta_r;

  // ------------------------------------------------------------
  // crossing
  // ------------------------------------------------------------
  // the first stage feeds only the second one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// [testbench/vcp_top_props.sv]
/*
  vcp_top_props: bus and pixel port checks for vcp_top.
  Assumes: bound into vcp_top; hresetn resets both clock domains.
*/
`timescale 1ns/100ps
module vcp_top_props (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // reset
  input wire logic hsel, // select
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic pix_clk, // pixel clock
  input wire logic line_sync_o, // line drive
  input wire logic line_sync_oe, // line enable
  input wire logic frame_sync_o, // frame drive
  input wire logic frame_sync_oe, // frame enable
  input wire vcp_pkg::vcp_pix_type pix_o // pixel
);
  import vcp_pkg::*;
  logic rd_go;
  logic wr_go;
  // transfers taken at this edge
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wr_go = hsel && hready && htrans[1] && hwrite;
  property p_okay; @(posedge hclk) disable iff (!hresetn) !hresp; endproperty
  a_okay: assert property (p_okay) else $error("resp not okay");
  property p_rdw; @(posedge hclk) disable iff (!hresetn) rd_go |=> !hreadyout ##1 hreadyout; endproperty
  a_rdw: assert property (p_rdw) else $error("read wait wrong");
  property p_wrz; @(posedge hclk) disable iff (!hresetn) wr_go |=> hreadyout; endproperty
  a_wrz: assert property (p_wrz) else $error("write waited");
  // a released sync pin must not carry a stale drive value
  property p_lsi; @(posedge pix_clk) disable iff (!hresetn) !line_sync_oe |-> !line_sync_o; endproperty
  a_lsi: assert property (p_lsi) else $error("line drive idle");
  property p_fsi; @(posedge pix_clk) disable iff (!hresetn) !frame_sync_oe |-> !frame_sync_o; endproperty
  a_fsi: assert property (p_fsi) else $error("frame drive idle");
  property p_oep; @(posedge pix_clk) disable iff (!hresetn) line_sync_oe == frame_sync_oe; endproperty
  a_oep: assert property (p_oep) else $error("enables differ");
  property p_sol; @(posedge pix_clk) disable iff (!hresetn) pix_o.sol |=> !pix_o.sol; endproperty
  a_sol: assert property (p_sol) else $error("line start held");
  property p_fld; @(posedge pix_clk) disable iff (!hresetn)
    pix_o.valid && $past(pix_o.valid) && !pix_o.sof |-> $stable(pix_o.field); endproperty
  a_fld: assert property (p_fld) else $error("field moved");
  c_read: cover property (@(posedge hclk) rd_go);
  c_sof: cover property (@(posedge pix_clk) pix_o.sof);
  c_drive: cover property (@(posedge pix_clk) line_sync_oe);
endmodule

bind vcp_top vcp_top_props i_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .pix_clk, .line_sync_o, .line_sync_oe, .frame_sync_o, .frame_sync_oe, .pix_o);

// [testbench/vcp_sensor_model.sv]
/*
  vcp_sensor_model: image source making pixel clock, pixels and syncs.
  Assumes: the bench passes the control word; released syncs sink low.
*/
`timescale 1ns/100ps
module vcp_sensor_model #(
  parameter int PIX = 8, // pixels per line, multiple of four
  parameter int LINES = 3 // lines per frame
) (
  output logic pix_clk, // still between runs
  output logic [7:0] luma, // luma lines
  output logic [7:0] chroma, // chroma lines
  output logic ls, // line sync drive
  output logic fs, // frame sync drive
  output logic gate // gate or field pin
);
  import vcp_pkg::*;
  vcp_pix_type exp_q[$];
  initial begin
    {pix_clk, luma, chroma, ls, fs, gate} = '0;
  end
  // pins move mid low phase so either sampling edge sees them settled
  task automatic run(input int frames, input logic [9:0] c);
    int n, p, l, f;
    logic on;
    logic [1:0] k;
    vcp_pix_type e;
    n = frames * PIX * LINES;
    for (int i = -6; i < n + 6; i++) begin
      on = i >= 0 && i < n && !c[3];
      p = i % PIX;
      l = (i / PIX) % LINES;
      f = i / (PIX * LINES);
      k = 2'(p);
      luma = 8'($urandom);
      chroma = 8'($urandom);
      ls = on && p == 0;
      fs = on && p == 0 && l == 0;
      gate = c[4] ? f[0] : (p == 0 || $urandom_range(3) != 0);
      e = '0;
      e.sof = fs;
      e.sol = ls;
      e.field = c[4] & f[0];
      case (c[2:1])
        2'h0: e.data = {2'h0, chroma[5:0], luma};
        2'h1: begin
          e.data = {chroma, luma};
          e.comp = (k[0] ^ c[5]) ? VCP_COMP_CR : VCP_COMP_CB;
        end
        default: begin
          e.data = {8'h00, c[8] ? chroma : luma};
          e.comp = (k[0] != c[7]) ? VCP_COMP_Y : ((k[1] ^ c[6]) ? VCP_COMP_CR : VCP_COMP_CB);
        end
      endcase
      if (on && (c[4] || gate)) exp_q.push_back(e);
      #3 pix_clk = 1'b1;
      #6 pix_clk = 1'b0;
      #3;
    end
  endtask
endmodule

// [testbench/video_capture_input_port_test.sv]
/*
  video_capture_input_port_test: self-checking bench for vcp_top.
  Assumes: vcp_sensor_model makes the pixel clock and notes expected pixels.
*/
`timescale 1ns/100ps
module video_capture_input_port_test;
  import vcp_pkg::*;
  logic hclk, hresetn, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic hreadyout, hresp, pix_clk, ls_m, fs_m, gate;
  logic [7:0] luma, chroma;
  logic line_sync_o, line_sync_oe, frame_sync_o, frame_sync_oe;
  logic [9:0] cfg;
  vcp_pix_type pix_o, e;
  int errors = 0;
  int check_count = 0;
  int ticks = 0;
  // raw field, raw gate, raw falling edge, yc16 both orders, yc8 every order
  logic [9:0] tbl [9] = '{10'h010, 10'h000, 10'h200, 10'h002, 10'h022, 10'h004, 10'h144, 10'h084, 10'h1C4};
  // pads: the far side lets a released sync pin fall low
  vcp_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .pix_clk, .luma_input_lines(luma), .chroma_input_lines(chroma),
    .line_sync_i(line_sync_oe ? line_sync_o : ls_m), .line_sync_o, .line_sync_oe,
    .frame_sync_i(frame_sync_oe ? frame_sync_o : fs_m), .frame_sync_o, .frame_sync_oe,
    .write_gate_or_field_id(gate), .pix_o);
  vcp_sensor_model i_sensor (.pix_clk, .luma, .chroma, .ls(ls_m), .fs(fs_m), .gate);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single transfer; waits on hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // high time and period of a driven sync, in pixels
  task automatic measure(input logic fr, input int hi, input int per);
    int a = 0;
    int b = 0;
    wait (!(fr ? frame_sync_o : line_sync_o));
    do @(posedge pix_clk); while ((fr ? frame_sync_o : line_sync_o) !== 1'b1);
    while ((fr ? frame_sync_o : line_sync_o) === 1'b1) begin
      a++;
      @(posedge pix_clk);
    end
    while ((fr ? frame_sync_o : line_sync_o) !== 1'b1) begin
      b++;
      @(posedge pix_clk);
    end
    check(a, hi);
    check(a + b, per);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      errors++;
      final_report;
    end
  end
  // oldest note against each captured pixel
  always @(posedge pix_clk) begin
    #1;
    if (pix_o.valid === 1'b1 && i_sensor.exp_q.size() > 0) begin
      e = i_sensor.exp_q.pop_front();
      check({pix_o.sof, pix_o.sol, pix_o.field, pix_o.data}, {e.sof, e.sol, e.field, e.data});
      check(pix_o.comp, e.comp);
    end
  end
  initial begin
    void'($urandom(32'h1E74CB1B));
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    cfg = 10'h000;
    fork
      i_sensor.run(0, 10'h000);
    join_none
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(VCP_OFS_CTRL, 32'h0);
    rdchk(VCP_OFS_HTIM, {VCP_HWIDTH_RST, VCP_HPERIOD_RST});
    rdchk(VCP_OFS_VTIM, {VCP_VWIDTH_RST, VCP_VPERIOD_RST});
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    rdchk(8'h10, 32'h0);
    foreach (tbl[i]) begin
      cfg = tbl[i];
      bus(1'b1, VCP_OFS_CTRL, 32'h0);
      bus(1'b1, VCP_OFS_CTRL, {22'h0, cfg});
      i_sensor.run(0, cfg);
      bus(1'b1, VCP_OFS_CTRL, {22'h0, cfg} | 32'h1);
      i_sensor.run(2, cfg);
    end
    check(i_sensor.exp_q.size(), 0);
    bus(1'b0, VCP_OFS_STAT, 32'h0);
    check(rd[15:0], 16'h0012);
    cfg = 10'h008;
    bus(1'b1, VCP_OFS_CTRL, 32'h0);
    bus(1'b1, VCP_OFS_HTIM, 32'h0003000A);
    bus(1'b1, VCP_OFS_VTIM, 32'h00020004);
    bus(1'b1, VCP_OFS_CTRL, 32'h8);
    i_sensor.run(0, cfg);
    bus(1'b1, VCP_OFS_CTRL, 32'h9);
    bus(1'b1, VCP_OFS_HTIM, 32'h00050007);
    rdchk(VCP_OFS_HTIM, 32'h0003000A);
    bus(1'b1, VCP_OFS_CTRL, 32'h3);
    rdchk(VCP_OFS_CTRL, 32'h9);
    fork
      i_sensor.run(6, cfg);
      begin
        measure(1'b0, 3, 10);
        measure(1'b1, 20, 40);
        check(line_sync_oe, 1'b1);
      end
    join
    final_report;
  end
endmodule
